// *** subswap_pkg.sv ***
package subswap_pkg;
   // ------------------------------------------------------------
   // Register map (byte offsets, low 12 address bits decoded)
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_OPCODE  = 12'h000; // Write executes
   localparam logic [11:0] OFS_ACC     = 12'h004; // Accumulator
   localparam logic [11:0] OFS_STATUS  = 12'h008; // Flags
   localparam logic [2:0]  FILE_WIN    = 3'h1;    // haddr[11:9] window
   // ------------------------------------------------------------
   // Status field positions and reset values
   // ------------------------------------------------------------
   localparam int          BIT_C       = 0;
   localparam int          BIT_NB      = 1;       // Nibble borrow flag
   localparam int          BIT_Z       = 2;
   localparam logic [7:0]  ACC_RST     = 8'h00;
   localparam logic [2:0]  STATUS_RST  = 3'h0;
   localparam logic [13:0] OPCODE_RST  = 14'h0000;
   localparam logic [7:0]  FILE_RST    = 8'h00;
   // ------------------------------------------------------------
   // Opcode patterns
   // ------------------------------------------------------------
   localparam logic [4:0]  LIT_PAT     = 5'h1e;   // Bits 13:9
   localparam logic [5:0]  SUBF_PAT    = 6'h02;   // Bits 13:8
   localparam logic [5:0]  SWAP_PAT    = 6'h0e;   // Bits 13:8
   localparam int          DEST_BIT    = 7;
   localparam int          FILE_DEPTH  = 128;
   // Decoded operation
   typedef enum logic [1:0] {
      OP_NONE,
      OP_LIT,
      OP_SUBF,
      OP_SWAP
   } op_t;
endpackage

// *** alu_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Carrier between the register shell and the arithmetic slice
interface alu_if;
   logic [13:0]         opcode;   // Instruction word
   logic [7:0]          acc;      // Accumulator value
   logic [7:0]          fval;     // Addressed file register
   subswap_pkg::op_t    op;       // Decoded operation
   logic [7:0]          minuend;  // Left operand of subtraction
   logic [7:0]          result;   // Result byte
   logic                to_file;  // Result goes to the file register
   logic                flag_we;  // Flags are updated
   logic                c;        // Carry, inverted borrow
   logic                nibble_borrow_flag; // No borrow out of bit 3
   logic                z;        // Zero result
   modport core (output opcode, acc, fval,
                 input  op, minuend, result, to_file, flag_we, c,
                        nibble_borrow_flag, z);
   modport alu  (input  opcode, acc, fval,
                 output op, minuend, result, to_file, flag_we, c,
                        nibble_borrow_flag, z);
endinterface
`default_nettype wire

// *** subswap_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
// Combinational decode and arithmetic for the three operations
module subswap_alu (
   alu_if.alu a
);
   logic [8:0] diff;   // Nine bits so the borrow is visible
   logic [4:0] ndiff;  // Low nibble difference
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   always_comb begin
      // Bit 8 of the literal form is ignored
      if (a.opcode[13:9] == subswap_pkg::LIT_PAT) begin
         a.op = subswap_pkg::OP_LIT;
      end else if (a.opcode[13:8] == subswap_pkg::SUBF_PAT) begin
         a.op = subswap_pkg::OP_SUBF;
      end else if (a.opcode[13:8] == subswap_pkg::SWAP_PAT) begin
         a.op = subswap_pkg::OP_SWAP;
      end else begin
         a.op = subswap_pkg::OP_NONE;
      end
   end
   // ------------------------------------------------------------
   // Datapath
   // ------------------------------------------------------------
   always_comb begin
      a.minuend = (a.op == subswap_pkg::OP_LIT) ? a.opcode[7:0] : a.fval;
      diff      = {1'b0, a.minuend} - {1'b0, a.acc};
      ndiff     = {1'b0, a.minuend[3:0]} - {1'b0, a.acc[3:0]};
      a.to_file = (a.op != subswap_pkg::OP_LIT)
                  && a.opcode[subswap_pkg::DEST_BIT];
      a.flag_we = (a.op == subswap_pkg::OP_LIT)
                  || (a.op == subswap_pkg::OP_SUBF);
      if (a.op == subswap_pkg::OP_SWAP) begin
         a.result = {a.fval[3:0], a.fval[7:4]};
      end else begin
         a.result = diff[7:0];
      end
      a.c  = ~diff[8];
      a.nibble_borrow_flag = ~ndiff[4];
      a.z  = (diff[7:0] == 8'h00);
   end
endmodule
`default_nettype wire

// *** subtract_swap_datapath.sv ***
// What this block does
// - Literal minus accumulator into accumulator
// - File minus accumulator, destination bit steers
// - Carry set when no borrow
// - Carry cleared on borrow, result wraps
// - Equal operands give zero, carry set
// - Nibble exchange, destination steers, flags kept
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module subtract_swap_datapath (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0]  acc_ff;                       // Working accumulator
   logic [2:0]  st_ff;                        // Carry, nibble, zero
   logic [13:0] opc_ff;                       // Last executed word
   logic [7:0]  file_ff [subswap_pkg::FILE_DEPTH]; // File registers
   logic        wph_ff;                       // Write data phase due
   logic [11:0] waddr_ff;                     // Latched write address
   logic [31:0] hrdata_ff;                    // Read data
   logic        hreadyout_ff;                 // Never stalls
   logic        hresp_ff;                     // Always OKAY
   logic        aph;                          // Address phase taken
   logic        exec;                         // Opcode write lands
   logic        fwr;                          // Bus write to a file reg
   logic [6:0]  fidx;                         // Operand index
   alu_if aif ();

   subswap_alu u_alu (
      .a (aif.alu)
   );

   // Size ignored: only whole words are used
   assign aph       = hsel && htrans[1] && hready;
   assign exec      = wph_ff && (waddr_ff == subswap_pkg::OFS_OPCODE);
   assign fwr       = wph_ff && (waddr_ff[11:9] == subswap_pkg::FILE_WIN);
   // Operand index and instruction ride on the data-phase word
   assign fidx      = hwdata[6:0];
   assign aif.opcode = hwdata[13:0];
   assign aif.acc    = acc_ff;
   assign aif.fval   = file_ff[fidx];
   assign hrdata     = hrdata_ff;
   assign hreadyout  = hreadyout_ff;
   assign hresp      = hresp_ff;

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   // Zero wait states; writes land at the data phase edge
   always_ff @(posedge clk) begin
      if (rst) begin
         wph_ff       <= 1'b0;
         waddr_ff     <= 12'h000;
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end else begin
         wph_ff       <= aph && hwrite;
         waddr_ff     <= haddr[11:0];
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end
   end

   // Read data captured in the address phase
   // A read right behind a write to the same place sees the old
   // value; one idle cycle between them shows the new one
   always_ff @(posedge clk) begin
      if (rst) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (aph && !hwrite) begin
         if (haddr[11:0] == subswap_pkg::OFS_ACC) begin
            hrdata_ff <= {24'h00_0000, acc_ff};
         end else if (haddr[11:0] == subswap_pkg::OFS_STATUS) begin
            hrdata_ff <= {29'h000_0000, st_ff};
         end else if (haddr[11:0] == subswap_pkg::OFS_OPCODE) begin
            hrdata_ff <= {18'h0_0000, opc_ff};
         end else if (haddr[11:9] == subswap_pkg::FILE_WIN) begin
            hrdata_ff <= {24'h00_0000, file_ff[haddr[8:2]]};
         end else begin
            // Unmapped reads return zero
            hrdata_ff <= 32'h0000_0000;
         end
      end
   end

   // ------------------------------------------------------------
   // Architectural state
   // ------------------------------------------------------------
   // Accumulator: bus write or result with destination clear
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_ff <= subswap_pkg::ACC_RST;
      end else if (exec && aif.op != subswap_pkg::OP_NONE
                   && !aif.to_file) begin
         acc_ff <= aif.result;
      end else if (wph_ff && waddr_ff == subswap_pkg::OFS_ACC) begin
         acc_ff <= hwdata[7:0];
      end
   end

   // Flags: subtraction wins over a software write
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= subswap_pkg::STATUS_RST;
      end else if (exec && aif.flag_we) begin
         st_ff[subswap_pkg::BIT_C]  <= aif.c;
         st_ff[subswap_pkg::BIT_NB] <= aif.nibble_borrow_flag;
         st_ff[subswap_pkg::BIT_Z]  <= aif.z;
      end else if (wph_ff && waddr_ff == subswap_pkg::OFS_STATUS) begin
         st_ff <= hwdata[2:0];
      end
   end

   // Last instruction word, readable for debug
   always_ff @(posedge clk) begin
      if (rst) begin
         opc_ff <= subswap_pkg::OPCODE_RST;
      end else if (exec) begin
         opc_ff <= hwdata[13:0];
      end
   end

   // File registers: one writer per entry, result or bus
   for (genvar i = 0; i < subswap_pkg::FILE_DEPTH; i++) begin : g_file
      always_ff @(posedge clk) begin
         if (rst) begin
            file_ff[i] <= subswap_pkg::FILE_RST;
         end else if (exec && aif.to_file && fidx == 7'(i)) begin
            file_ff[i] <= aif.result;
         end else if (fwr && waddr_ff[8:2] == 7'(i)) begin
            file_ff[i] <= hwdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Execute strobes: literal, file-destination subtract, any subtraction, swap, undecoded word
   sequence s_lit;
      exec && aif.op == subswap_pkg::OP_LIT;
   endsequence
   sequence s_subf_file;
      exec && aif.op == subswap_pkg::OP_SUBF && aif.to_file;
   endsequence
   sequence s_sub;
      exec && aif.flag_we;
   endsequence
   sequence s_swap;
      exec && aif.op == subswap_pkg::OP_SWAP;
   endsequence
   sequence s_none;
      exec && aif.op == subswap_pkg::OP_NONE;
   endsequence

   // Results land one edge after the execute strobe
   a_lit_to_acc: assert property (
      s_lit |=> acc_ff == 8'($past(hwdata[7:0]) - $past(acc_ff)))
      else $error("literal subtract wrong accumulator");
   a_subf_to_file: assert property (
      s_subf_file |=> file_ff[$past(fidx)] ==
         8'($past(aif.fval) - $past(acc_ff)) && $stable(acc_ff))
      else $error("file subtract wrong destination");

   // Carry is the inverted borrow of the whole byte
   a_carry_set: assert property (
      s_sub and (aif.minuend >= acc_ff)
      |=> st_ff[subswap_pkg::BIT_C])
      else $error("carry not set without borrow");
   a_carry_clr: assert property (
      s_sub and (aif.minuend < acc_ff)
      |=> !st_ff[subswap_pkg::BIT_C])
      else $error("carry not cleared on borrow");
   a_equal_zero: assert property (
      s_sub and (aif.minuend == acc_ff)
      |-> aif.result == 8'h00 ##1 st_ff[subswap_pkg::BIT_C]
          && st_ff[subswap_pkg::BIT_Z])
      else $error("equal operands not zero");

   // Nibble exchange touches no flag and places its result; subtraction sets the zero and nibble flags
   a_swap_flags: assert property (
      s_swap ##1 1'b1 |-> $stable(st_ff)
         && ($past(aif.to_file) ||
             acc_ff == {$past(aif.fval[3:0]), $past(aif.fval[7:4])}))
      else $error("nibble exchange wrong");
   a_swap_to_file: assert property (
      s_swap and (aif.to_file) |=> $stable(acc_ff) && file_ff[$past(fidx)]
         == {$past(aif.fval[3:0]), $past(aif.fval[7:4])})
      else $error("nibble exchange wrong file register");
   a_zero_nibble: assert property (
      s_sub |=> st_ff[subswap_pkg::BIT_Z] ==
            ($past(aif.minuend) == $past(acc_ff))
         && st_ff[subswap_pkg::BIT_NB] ==
            ($past(aif.minuend[3:0]) >= $past(acc_ff[3:0])))
      else $error("zero or nibble flag wrong");

   // Undecoded words leave the accumulator and flags alone
   a_none_quiet: assert property (
      s_none |=> $stable(acc_ff) && $stable(st_ff))
      else $error("undecoded word changed state");
   // Zero wait states and OKAY only, so a master never stalls
   a_bus_okay: assert property (
      hreadyout && !hresp)
      else $error("slave stalled or errored");
endmodule
`default_nettype wire

// *** tb_subtract_swap_datapath.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_subtract_swap_datapath;
   // ------------------------------------------------------------
   // Bus wires and model state
   // ------------------------------------------------------------
   logic        clk;         // 250 MHz core clock
   logic        rst;         // Synchronous reset, high
   logic        hsel;        // Slave select
   logic [31:0] haddr;       // Byte address
   logic [1:0]  htrans;      // Transfer kind
   logic        hwrite;      // Write strobe
   logic [2:0]  hsize;       // Always a word
   logic [31:0] hwdata;      // Write data
   logic [31:0] hrdata;      // Read data
   logic        hreadyout;   // Slave ready, also bus ready
   logic        hresp;       // Response, always OKAY
   logic [31:0] rd;          // Last read word
   logic [2:0]  st_m;        // Model flags
   logic [13:0] opw;         // Instruction word sent
   int          failures;    // Mismatch count
   int          n_compared;  // Compare count
   int          cyc;         // Cycle count for hang guard
   int          seed;        // Random seed
   int          acc_m;       // Model accumulator
   int          file_m[128]; // Model file registers
   int          f, k, d, op, r;

   subtract_swap_datapath subtract_swap_datapath_i (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));

   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Hang guard: far above the roughly 1000 cycles needed
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 8000) begin
         failures = failures + 1;
         results();
      end
   end

   // ------------------------------------------------------------
   // Bus tasks and comparison
   // ------------------------------------------------------------
   // One single transfer; waits on ready, never a fixed count
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string nm);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input int v);
      bus(1'b1, a, 32'(v), rd);
   endtask

   // Read-back; the write before it has already landed
   task automatic chk_rd(input logic [11:0] a, input int v, input string nm);
      bus(1'b0, a, 32'h00000000, rd);
      check(rd, 32'(v), nm);
      check({31'h0, hresp}, 32'h0, "hresp");
   endtask

   task automatic results;
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
      failures = 0; n_compared = 0; cyc = 0; seed = 48;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Unmapped place takes writes silently and reads zero
      wr(12'h00c, 32'hff);
      chk_rd(12'h00c, 0, "unmapped");
      // Every fifth pass repeats an operation; some operands equal
      for (int i = 0; i < 60; i++) begin
         op = i % 5;
         d = (op == 2 || op == 4) ? 1 : 0;
         acc_m = $random(seed) & 255;
         f = $random(seed) & 127;
         k = (i % 7 == 0) ? acc_m : $random(seed) & 255;
         st_m = 3'($random(seed));
         file_m[f] = k;
         wr(subswap_pkg::OFS_ACC, acc_m);
         wr(subswap_pkg::OFS_STATUS, 32'(st_m));
         wr({subswap_pkg::FILE_WIN, 7'(f), 2'b00}, k);
         // Bit 8 toggles as a don't-care
         case (op)
            0: opw = {subswap_pkg::LIT_PAT, 1'(i / 5), 8'(k)};
            1, 2: opw = {subswap_pkg::SUBF_PAT, 1'(d), 7'(f)};
            default: opw = {subswap_pkg::SWAP_PAT, 1'(d), 7'(f)};
         endcase
         if (op < 3) begin
            r = (k - acc_m) & 255;
            st_m = {1'(r == 0), 1'((k % 16) >= (acc_m % 16)),
                    1'(k >= acc_m)};
         end else begin
            r = ((k % 16) * 16) + (k / 16);
         end
         if (d == 1) file_m[f] = r;
         else acc_m = r;
         wr(subswap_pkg::OFS_OPCODE, 32'(opw));
         chk_rd(subswap_pkg::OFS_ACC, acc_m, "acc");
         chk_rd(subswap_pkg::OFS_STATUS, st_m, "flags");
         chk_rd(subswap_pkg::OFS_OPCODE, opw, "opcode");
         chk_rd({subswap_pkg::FILE_WIN, 7'(f), 2'b00}, file_m[f],
                "file");
      end
      // Undecoded word: kept for read-back, accumulator and flags untouched
      opw = {6'h3f, 8'($random(seed))};
      wr(subswap_pkg::OFS_OPCODE, 32'(opw));
      chk_rd(subswap_pkg::OFS_OPCODE, opw, "opcode");
      chk_rd(subswap_pkg::OFS_ACC, acc_m, "acc kept");
      chk_rd(subswap_pkg::OFS_STATUS, st_m, "flags kept");
      results();
   end
endmodule
`default_nettype wire
